// File: shared/mtw_map.svh
// Register offsets, field positions, encodings and reset values of the table walker
`ifndef MTW_MAP_SVH
`define MTW_MAP_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MTW_OFS_TC     8'h00
`define MTW_OFS_TROOT  8'h04
`define MTW_OFS_SROOT  8'h08
`define MTW_OFS_STAT   8'h0c
`define MTW_OFS_MASK   8'h10
`define MTW_OFS_FADDR  8'h14
`define MTW_OFS_FLUSH  8'h18
// ----------------------------------------------------------------------
// Control bit positions and reset values
// ----------------------------------------------------------------------
`define MTW_TC_E       31
`define MTW_TC_SRE     25
`define MTW_TC_FCL     24
`define MTW_TC_RST     32'h0000_0000
`define MTW_ROOT_RST   32'h0000_0000
`define MTW_MASK_RST   4'h0
// ----------------------------------------------------------------------
// Descriptor type codes and descriptor bit positions
// ----------------------------------------------------------------------
`define MTW_DT_INV     2'h0
`define MTW_DT_PAGE    2'h1
`define MTW_DT_SHORT   2'h2
`define MTW_DT_LONG    2'h3
`define MTW_DSC_WP     2
`define MTW_DSC_SUP    8
// ----------------------------------------------------------------------
// Event bits of status and mask
// ----------------------------------------------------------------------
`define MTW_EV_BERR    0
`define MTW_EV_INV     1
`define MTW_EV_SUP     2
`define MTW_EV_WP      3
`endif

// File: shared/mtw_pkg.sv
// Types shared by the table walker and its translation cache
package mtw_pkg;
    // Access request from the execution unit
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  fc;
        logic        wr;
        logic        move_alternate_space_instr;
        logic [2:0]  alt_fc;
    } mtw_acc_t;

    // Answer to an access
    typedef struct packed {
        logic        valid;
        logic        berr;
        logic [2:0]  fc;
        logic [31:0] paddr;
    } mtw_rsp_t;

    // One translation cache entry
    typedef struct packed {
        logic        valid;
        logic [2:0]  fc;
        logic [19:0] page;
        logic [19:0] frame;
        logic        wp;
        logic        err;
    } mtw_ent_t;
endpackage : mtw_pkg

// File: hdl/mtw_atc.sv
// Fully associative translation cache held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module mtw_atc
    import mtw_pkg::*;
#(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rstn,
    // Invalidate all
    input  wire logic     flush,
    // Lookup
    input  wire logic [2:0]  look_fc,
    input  wire logic [19:0] look_page,
    output logic          hit,
    output mtw_ent_t      hit_ent,
    // Fill
    input  wire logic     fill,
    input  wire mtw_ent_t fill_ent
);
    localparam int PW = (N > 1) ? $clog2(N) : 1;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (N < 2) begin : g_bad_n
        $error("mtw_atc needs at least two entries");
    end

    mtw_ent_t          ent [N];
    logic [N-1:0]      match;
    logic [PW-1:0]     victim;

    // ------------------------------------------------------------------
    // Per-entry storage and tag compare
    // ------------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_ent
        assign match[i] = ent[i].valid && ent[i].fc == look_fc && ent[i].page == look_page;

        // Flush wins over a fill in the same cycle
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                ent[i] <= '0;
            end else if (flush) begin
                ent[i] <= '0;
            end else if (fill && victim == PW'(i)) begin
                ent[i] <= fill_ent;
            end
        end
    end

    // Hit select, first matching entry
    always_comb begin
        hit     = 1'b0;
        hit_ent = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (match[k]) begin
                hit     = 1'b1;
                hit_ent = ent[k];
            end
        end
    end

    // Round-robin victim; cheap, no use tracking needed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            victim <= '0;
        end else if (fill) begin
            victim <= (victim == PW'(N - 1)) ? '0 : victim + 1'b1;
        end
    end
endmodule : mtw_atc
`default_nettype wire

// File: hdl/mtw_top.sv
// Paged table walker with protection checks, translation cache and APB registers
//
// Functional notes
// RL1: Indirect target typed short or long is invalid; entry gets error flag.
// RL2: Invalid table descriptor means absent table; retried access takes bus error.
// RL3: Invalid descriptor: only type field is read, nothing else used or changed.
// RL4: Every answered access carries its function code.
// RL5: Function-code lookup bit set: first table level indexed by function code.
// RL6: Supervisor-root enable set: supervisor accesses walk from supervisor root.
// RL7: Write-protect bit honoured at any level, covering whole branch below.
// RL8: Supervisor-only bit checked in long descriptors only.
// RL9: User access meeting supervisor-only bit ends walk with fault entry.
// RL10: Retried user access hitting fault entry takes bus error.
// RL11: Write-protect bit met in walk gives entry with write-protect flag.
// RL12: Write through write-protected entry takes bus error; reads proceed.
// RL13: Move-alternate-space access translates with the alternate function code.
// RL14: Protection follows walked path; shared tables inherit each task's bits.
// RL15: Last-level short/long entry is indirect pointer, upper 30 bits address.
// RL16: Supervisor-root enable clear: all accesses walk from task root.
// RL17: Function-code lookup ignores root limit for first level.
// RL18: Supervisor-only bit never faults supervisor-level accesses.
`timescale 1ns/1ps
`default_nettype none
`include "mtw_map.svh"
module mtw_top
    import mtw_pkg::*;
#(
    parameter int ATC_N = 4
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Execution unit
    input  wire logic        ACC_VALID,
    input  wire mtw_acc_t    ACC_REQ,
    output logic             ACC_READY,
    output mtw_rsp_t         RSP,
    // Table memory
    output logic             MEM_REQ,
    output logic [31:0]      MEM_ADDR,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ACK,
    // Interrupt
    output logic             IRQ
);
    typedef enum logic [2:0] {ST_IDLE, ST_LOOK, ST_FETCH, ST_EVAL, ST_FILL} mtw_state_t;

    // ------------------------------------------------------------------
    // Registers and walk state
    // ------------------------------------------------------------------
    logic [31:0] tc;
    logic [31:0] troot;
    logic [31:0] sroot;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [31:0] faddr;
    logic        flush;
    mtw_state_t  state;
    logic [31:0] la;
    logic [2:0]  efc;
    logic        wr;
    logic [1:0]  level;
    logic        lng;
    logic        word1;
    logic        indir;
    logic        wp_acc;
    logic        at_root;
    logic [31:0] dsc0;
    logic [31:0] dsc1;
    mtw_ent_t    new_ent;
    logic [3:0]  ev;
    logic        atc_hit;
    mtw_ent_t    atc_ent;

    wire         apb_wr  = PSEL && PENABLE && PREADY && PWRITE;
    wire         is_user = !efc[2];
    wire [31:0]  root_sel = (tc[`MTW_TC_SRE] && efc[2]) ? sroot : troot; // RL6 RL16

    // ------------------------------------------------------------------
    // Translation cache
    // ------------------------------------------------------------------
    mtw_atc #(.N(ATC_N)) u_atc (
        .clk      (MCLK),
        .rstn     (RSTN),
        .flush    (flush),
        .look_fc  (efc),
        .look_page(la[31:12]),
        .hit      (atc_hit),
        .hit_ent  (atc_ent),
        .fill     (state == ST_FILL),
        .fill_ent (new_ent)
    );

    // ------------------------------------------------------------------
    // APB: three-cycle access, pready one cycle after penable
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
            if (PSEL && PENABLE && !PREADY) begin
                if (PADDR == `MTW_OFS_TC) begin
                    PRDATA <= tc;
                end else if (PADDR == `MTW_OFS_TROOT) begin
                    PRDATA <= troot;
                end else if (PADDR == `MTW_OFS_SROOT) begin
                    PRDATA <= sroot;
                end else if (PADDR == `MTW_OFS_STAT) begin
                    PRDATA <= {28'h0, stat};
                end else if (PADDR == `MTW_OFS_MASK) begin
                    PRDATA <= {28'h0, mask};
                end else if (PADDR == `MTW_OFS_FADDR) begin
                    PRDATA <= faddr;
                end else if (PADDR != `MTW_OFS_FLUSH) begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tc    <= `MTW_TC_RST;
            troot <= `MTW_ROOT_RST;
            sroot <= `MTW_ROOT_RST;
            mask  <= `MTW_MASK_RST;
            flush <= 1'b0;
        end else begin
            flush <= apb_wr && PADDR == `MTW_OFS_FLUSH;
            if (apb_wr && PADDR == `MTW_OFS_TC) begin
                tc <= PWDATA & 32'h8300_0000;
            end
            if (apb_wr && PADDR == `MTW_OFS_TROOT) begin
                troot <= PWDATA & 32'hffff_fff3;
            end
            if (apb_wr && PADDR == `MTW_OFS_SROOT) begin
                sroot <= PWDATA & 32'hffff_fff3;
            end
            if (apb_wr && PADDR == `MTW_OFS_MASK) begin
                mask <= PWDATA[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky events: a new event wins over a write-one clear
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            stat <= '0;
            IRQ  <= 1'b0;
        end else begin
            stat <= (stat & ~((apb_wr && PADDR == `MTW_OFS_STAT) ? PWDATA[3:0] : 4'h0)) | ev;
            IRQ  <= |(stat & mask);
        end
    end

    // ------------------------------------------------------------------
    // Descriptor decode of the fetched entry
    // ------------------------------------------------------------------
    wire [1:0]  d_dt   = dsc0[1:0];
    wire [31:0] d_addr = lng ? {dsc1[31:4], 4'h0} : {dsc0[31:4], 4'h0};
    wire        d_wp   = dsc0[`MTW_DSC_WP];
    wire        d_sup  = lng && dsc0[`MTW_DSC_SUP]; // RL8

    // Table index per level, scaled by descriptor size
    logic [9:0]  idx;
    logic [31:0] nbase;
    always_comb begin
        idx = (level == 2'd0) ? {7'h0, efc} : (level == 2'd1) ? la[31:22] : la[21:12];
        nbase = d_addr;
    end

    // ------------------------------------------------------------------
    // Walk sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state     <= ST_IDLE;
            ACC_READY <= 1'b0;
            RSP       <= '0;
            MEM_REQ   <= 1'b0;
            MEM_ADDR  <= '0;
            la        <= '0;
            efc       <= '0;
            wr        <= 1'b0;
            level     <= '0;
            lng       <= 1'b0;
            word1     <= 1'b0;
            indir     <= 1'b0;
            wp_acc    <= 1'b0;
            at_root   <= 1'b0;
            dsc0      <= '0;
            dsc1      <= '0;
            new_ent   <= '0;
            ev        <= '0;
            faddr     <= '0;
        end else begin
            RSP.valid <= 1'b0;
            ev        <= '0;
            case (state)
                ST_IDLE: begin
                    ACC_READY <= 1'b1;
                    if (ACC_VALID && ACC_READY) begin
                        ACC_READY <= 1'b0;
                        la        <= ACC_REQ.addr;
                        efc       <= ACC_REQ.move_alternate_space_instr ? ACC_REQ.alt_fc : ACC_REQ.fc; // RL13
                        wr        <= ACC_REQ.wr;
                        state     <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    RSP.fc <= efc; // RL4
                    if (!tc[`MTW_TC_E]) begin
                        // Translation off: logical is physical
                        RSP   <= '{1'b1, 1'b0, efc, la};
                        state <= ST_IDLE;
                    end else if (atc_hit) begin
                        RSP.valid <= 1'b1;
                        RSP.paddr <= {atc_ent.frame, la[11:0]};
                        RSP.berr  <= atc_ent.err || (atc_ent.wp && wr); // RL2 RL10 RL12
                        if (atc_ent.err || (atc_ent.wp && wr)) begin
                            ev[`MTW_EV_BERR] <= 1'b1;
                            faddr            <= la;
                        end
                        state <= ST_IDLE;
                    end else begin
                        // Root choice by privilege; limit field is not used at all
                        wp_acc  <= 1'b0;
                        indir   <= 1'b0;
                        at_root <= 1'b1;
                        dsc0    <= root_sel; // RL6 RL16
                        dsc1    <= {root_sel[31:4], 4'h0};
                        lng     <= 1'b0;
                        level   <= tc[`MTW_TC_FCL] ? 2'd0 : 2'd1; // RL5 RL17
                        state   <= ST_EVAL;
                    end
                end
                ST_FETCH: begin
                    if (MEM_ACK) begin
                        if (lng && !word1) begin
                            // Long format: control word then address word
                            dsc0     <= MEM_RDATA;
                            word1    <= 1'b1;
                            MEM_ADDR <= MEM_ADDR + 32'h4;
                        end else begin
                            MEM_REQ <= 1'b0;
                            if (lng) begin
                                dsc1 <= MEM_RDATA;
                            end else begin
                                dsc0 <= MEM_RDATA;
                            end
                            level <= (level == 2'd3) ? level : level + 2'd1;
                            state <= ST_EVAL;
                        end
                    end
                end
                ST_EVAL: begin
                    // Entry skeleton, refined below
                    new_ent <= '{1'b1, efc, la[31:12], 20'h0, wp_acc | d_wp, 1'b0};
                    wp_acc  <= wp_acc | d_wp; // RL7 RL14
                    word1   <= 1'b0;
                    at_root <= 1'b0;
                    state   <= ST_FILL;
                    if (d_dt == `MTW_DT_INV || (indir && d_dt != `MTW_DT_PAGE)) begin
                        // Only the type field is looked at here
                        new_ent.err      <= 1'b1; // RL1 RL2 RL3
                        new_ent.wp       <= wp_acc; // RL3
                        ev[`MTW_EV_INV]  <= 1'b1;
                    end else if (d_sup && is_user) begin
                        new_ent.err      <= 1'b1; // RL9 RL18
                        ev[`MTW_EV_SUP]  <= 1'b1;
                    end else if (d_dt == `MTW_DT_PAGE) begin
                        // Root-level page maps with a constant offset
                        new_ent.frame <= at_root ? la[31:12] + d_addr[31:12] : d_addr[31:12];
                        ev[`MTW_EV_WP] <= wp_acc | d_wp; // RL11
                    end else if (level == 2'd3) begin
                        // Index fields used up: follow the indirect pointer
                        MEM_ADDR <= {(lng ? dsc1[31:2] : dsc0[31:2]), 2'h0}; // RL15
                        lng      <= d_dt == `MTW_DT_LONG;
                        indir    <= 1'b1;
                        MEM_REQ  <= 1'b1;
                        state    <= ST_FETCH;
                    end else begin
                        MEM_ADDR <= nbase + (d_dt == `MTW_DT_LONG ? {19'h0, idx, 3'h0}
                                                                  : {20'h0, idx, 2'h0});
                        lng      <= d_dt == `MTW_DT_LONG;
                        MEM_REQ  <= 1'b1;
                        state    <= ST_FETCH;
                    end
                end
                ST_FILL: begin
                    // Entry written this cycle; lookup again acts as the retry
                    state <= ST_LOOK;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : mtw_top
`default_nettype wire

// File: testbench/mtw_mem_model.sv
// Translation table memory model for the walker's descriptor reads
`timescale 1ns/1ps
`default_nettype none
module mtw_mem_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Read port
    input  wire logic        req,
    input  wire logic [31:0] addr,
    output logic [31:0]      rdata,
    output logic             ack
);
    logic [31:0] mem [logic [31:0]];
    int          lat;
    int          cnt;
    // Answer after lat idle cycles; unwritten words read as invalid
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack   <= 1'b0;
            rdata <= 32'h0;
            cnt   <= 0;
        end else if (req && !ack && cnt >= lat) begin
            ack   <= 1'b1;
            rdata <= mem.exists(addr) ? mem[addr] : 32'h0;
            cnt   <= 0;
        end else begin
            // Scramble stale data so a late sample cannot pass
            ack   <= 1'b0;
            rdata <= ~rdata;
            cnt   <= (req && !ack) ? cnt + 1 : 0;
        end
    end
endmodule : mtw_mem_model
`default_nettype wire

// File: testbench/mtw_top_assertions.sv
// Concurrent checks on the table walker ports
`timescale 1ns/1ps
`default_nettype none
module mtw_top_assertions
    import mtw_pkg::*;
#(
    parameter int ATC_N = 4
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // Execution unit
    input  wire logic        ACC_VALID,
    input  wire mtw_acc_t    ACC_REQ,
    input  wire logic        ACC_READY,
    input  wire mtw_rsp_t    RSP,
    // Table memory
    input  wire logic        MEM_REQ,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic        MEM_ACK
);
    logic [2:0] t_fc;
    logic       t_move_alternate_space_instr;
    logic [2:0] t_alt;
    // Remember the taken request, the answer must echo it
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            t_fc    <= 3'h0;
            t_move_alternate_space_instr <= 1'b0;
            t_alt   <= 3'h0;
        end else if (ACC_VALID && ACC_READY) begin
            t_fc    <= ACC_REQ.fc;
            t_move_alternate_space_instr <= ACC_REQ.move_alternate_space_instr;
            t_alt   <= ACC_REQ.alt_fc;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence s_take;
        ACC_VALID && ACC_READY;
    endsequence
    sequence s_answer;
        ##[2:300] RSP.valid;
    endsequence
    resp_fc_a: assert property (RSP.valid |-> RSP.fc == (t_move_alternate_space_instr ? t_alt : t_fc))
        else $error("answer carries wrong function code");
    resp_pulse_a: assert property (RSP.valid |=> !RSP.valid)
        else $error("answer valid longer than one cycle");
    walk_bound_a: assert property (s_take |-> s_answer)
        else $error("access never answered");
    busy_take_a: assert property (s_take |=> !ACC_READY)
        else $error("ready stayed high after take");
    ready_back_a: assert property (RSP.valid |-> ##[1:2] ACC_READY)
        else $error("ready did not return after answer");
    idle_mem_a: assert property (ACC_READY |-> !MEM_REQ)
        else $error("table read while idle");
    mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("table read dropped or moved before ack");
    mem_align_a: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0)
        else $error("table read not word aligned");
endmodule : mtw_top_assertions
`default_nettype wire

// File: testbench/mtw_top_tb_top.sv
// Self-checking bench for the table walker
`timescale 1ns/1ps
`default_nettype none
`include "mtw_map.svh"
module mtw_top_tb_top
    import mtw_pkg::*;
;
    logic        MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        ACC_VALID, ACC_READY, MEM_REQ, MEM_ACK, IRQ, err;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, MEM_ADDR, MEM_RDATA, rd;
    mtw_acc_t    ACC_REQ;
    mtw_rsp_t    RSP;
    int          errors, n_compared;
    // Descriptor image: address, word pairs
    localparam logic [31:0] IMG [0:27] = '{
        32'h1004, 32'h2002, 32'h1008, 32'h2006, 32'h100c, 32'hdeadbee0,
        32'h2004, 32'h50001, 32'h2008, 32'h3002, 32'h200c, 32'h3012,
        32'h3000, 32'h70001, 32'h3010, 32'h4002, 32'h5004, 32'h6002,
        32'h6004, 32'h90001, 32'h7008, 32'h102, 32'h700c, 32'h2000,
        32'h8004, 32'h1002, 32'h8008, 32'hab0};
    mtw_top #(.ATC_N(4)) mtw_top_inst (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACC_VALID, .ACC_REQ,
        .ACC_READY, .RSP, .MEM_REQ, .MEM_ADDR, .MEM_RDATA, .MEM_ACK, .IRQ);
    mtw_mem_model mtw_mem_model_inst (.clk(MCLK), .rstn(RSTN), .req(MEM_REQ),
        .addr(MEM_ADDR), .rdata(MEM_RDATA), .ack(MEM_ACK));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait step; a hang ends the run
    task automatic bump(inout int n);
        n++;
        if (n > 500) begin
            errors++;
            $display("Error at %0t ns: wait ran out", $time);
            give_verdict();
        end
    endtask : bump
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            bump(n);
        end while (PREADY !== 1'b1);
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // Alt holds move_alternate_space_instr then alt_fc; paddr is only judged without bus error
    task automatic acc(input logic [31:0] a, input logic [2:0] fc, input logic w,
                       input logic [3:0] alt, input logic b, input logic [31:0] pa);
        int n;
        n = 0;
        @(posedge MCLK);
        ACC_VALID <= 1'b1;
        ACC_REQ   <= {a, fc, w, alt};
        do begin
            @(posedge MCLK);
            bump(n);
        end while (ACC_READY !== 1'b1);
        ACC_VALID <= 1'b0;
        do begin
            @(posedge MCLK);
            bump(n);
        end while (RSP.valid !== 1'b1);
        check(RSP.berr, b);
        if (!b) check(RSP.paddr, pa);
        check(RSP.fc, alt[3] ? alt[2:0] : fc);
    endtask : acc
    // ------------------------------------------------------------
    // Clock, reset and scenarios
    // ------------------------------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    initial begin
        {RSTN, PSEL, PENABLE, PWRITE, ACC_VALID} = '0;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        ACC_REQ = '0;
        errors = 0;
        n_compared = 0;
        for (int i = 0; i < 28; i += 2) mtw_mem_model_inst.mem[IMG[i]] = IMG[i+1];
        repeat (3) @(posedge MCLK);
        RSTN <= 1'b1;
        // Reset values, read-back masking, unmapped offset
        apb(1'b0, `MTW_OFS_TC, 32'h0);
        check(rd, `MTW_TC_RST);
        apb(1'b1, `MTW_OFS_TROOT, 32'h100f);
        apb(1'b0, `MTW_OFS_TROOT, 32'h0);
        check(rd, 32'h1003);
        apb(1'b0, 8'h1c, 32'h0);
        check(err, 1'b1);
        apb(1'b1, `MTW_OFS_TROOT, 32'h1002);
        acc(32'h1234_5678, 3'h2, 1'b0, 4'h0, 1'b0, 32'h1234_5678);
        apb(1'b1, `MTW_OFS_TC, 32'h8000_0000);
        apb(1'b1, `MTW_OFS_FLUSH, 32'h0);
        // Short tree from the task root
        acc(32'h0040_1234, 3'h1, 1'b0, 4'h0, 1'b0, 32'h0005_0234);
        acc(32'h0040_1000, 3'h5, 1'b0, 4'h0, 1'b0, 32'h0005_0000);
        acc(32'h0080_1010, 3'h1, 1'b0, 4'h0, 1'b0, 32'h0005_0010);
        acc(32'h0080_1010, 3'h1, 1'b1, 4'h0, 1'b1, 32'h0);
        acc(32'h0040_1010, 3'h1, 1'b1, 4'h0, 1'b0, 32'h0005_0010);
        acc(32'h00c0_0000, 3'h1, 1'b0, 4'h0, 1'b1, 32'h0);
        acc(32'h0040_2004, 3'h1, 1'b0, 4'h0, 1'b0, 32'h0007_0004);
        acc(32'h0040_3000, 3'h1, 1'b0, 4'h0, 1'b1, 32'h0);
        apb(1'b0, `MTW_OFS_FADDR, 32'h0);
        check(rd, 32'h0040_3000);
        apb(1'b0, `MTW_OFS_STAT, 32'h0);
        check(rd, 32'hb);
        check(IRQ, 1'b0);
        apb(1'b1, `MTW_OFS_MASK, 32'h2);
        // Read-back also lets the registered interrupt settle
        apb(1'b0, `MTW_OFS_MASK, 32'h0);
        check(rd, 32'h2);
        check(IRQ, 1'b1);
        apb(1'b1, `MTW_OFS_STAT, 32'hf);
        apb(1'b0, `MTW_OFS_STAT, 32'h0);
        check(rd, 32'h0);
        check(IRQ, 1'b0);
        // Long tree with a supervisor-only table, slow memory
        mtw_mem_model_inst.lat <= 2;
        apb(1'b1, `MTW_OFS_TROOT, 32'h7003);
        apb(1'b1, `MTW_OFS_FLUSH, 32'h0);
        acc(32'h0040_1000, 3'h1, 1'b0, 4'h0, 1'b1, 32'h0);
        acc(32'h0040_1000, 3'h1, 1'b0, 4'h0, 1'b1, 32'h0);
        acc(32'h0040_1000, 3'h5, 1'b0, 4'h0, 1'b0, 32'h0005_0000);
        apb(1'b0, `MTW_OFS_STAT, 32'h0);
        check(rd[`MTW_EV_SUP], 1'b1);
        // Separate supervisor tree and alternate space move_alternate_space_instr
        apb(1'b1, `MTW_OFS_TROOT, 32'h1002);
        apb(1'b1, `MTW_OFS_SROOT, 32'h5002);
        apb(1'b1, `MTW_OFS_TC, 32'h8200_0000);
        apb(1'b1, `MTW_OFS_FLUSH, 32'h0);
        acc(32'h0040_1000, 3'h5, 1'b0, 4'h0, 1'b0, 32'h0009_0000);
        acc(32'h0040_1000, 3'h6, 1'b0, 4'h0, 1'b0, 32'h0009_0000);
        acc(32'h0040_1000, 3'h1, 1'b0, 4'h0, 1'b0, 32'h0005_0000);
        acc(32'h0040_1000, 3'h5, 1'b0, 4'h9, 1'b0, 32'h0005_0000);
        // Function code as first table index
        apb(1'b1, `MTW_OFS_TROOT, 32'h8002);
        apb(1'b1, `MTW_OFS_TC, 32'h8100_0000);
        apb(1'b1, `MTW_OFS_FLUSH, 32'h0);
        acc(32'h0040_1234, 3'h1, 1'b0, 4'h0, 1'b0, 32'h0005_0234);
        acc(32'h0040_1234, 3'h2, 1'b0, 4'h0, 1'b1, 32'h0);
        give_verdict();
    end
endmodule : mtw_top_tb_top
bind mtw_top mtw_top_assertions #(.ATC_N(ATC_N)) mtw_top_assertions_inst (.MCLK,
    .RSTN, .ACC_VALID, .ACC_REQ, .ACC_READY, .RSP, .MEM_REQ, .MEM_ADDR, .MEM_ACK);
`default_nettype wire
